// >>> oss_regs.svh
// offsets, fields, reset values and counts of the status selector
`ifndef OSS_REGS_SVH
`define OSS_REGS_SVH

// clock and time base
`define OSS_CLK_PERIOD_NS   50
`define OSS_MS_NS           1000000
`define OSS_TENTH_MS        100
`define OSS_RS_HOLD_MS      1000
`define OSS_RS_HOLD_TENTHS  (`OSS_RS_HOLD_MS / `OSS_TENTH_MS)

// terminal function codes
`define OSS_FC_ZERO_FREQ    8'h15
`define OSS_FC_SPEED_DEV    8'h16
`define OSS_FC_POS_DONE     8'h17
`define OSS_FC_FREQ_OVER2   8'h18
`define OSS_FC_FREQ_AT2     8'h19
`define OSS_FC_OVERLOAD2    8'h1A
`define OSS_FC_VOLT_LOSS    8'h1B
`define OSS_FC_CURR_LOSS    8'h1C
`define OSS_FC_FB_WINDOW    8'h1F
`define OSS_FC_COMM_TMO     8'h20
`define OSS_FC_BOOL_A       8'h21
`define OSS_FC_BOOL_B       8'h22
`define OSS_FC_BOOL_C       8'h23
`define OSS_FC_CAP_LIFE     8'h27
`define OSS_FC_FAN_LIFE     8'h28
`define OSS_FUNC_RST        8'hFF

// byte offsets on the register bus
`define OSS_ADR_FUNC_BASE   8'h00
`define OSS_ADR_OFFDLY_BASE 8'h10
`define OSS_ADR_THR_BASE    8'h20
`define OSS_ADR_COND        8'h44
`define OSS_ADR_TERM        8'h48
`define OSS_ADR_IRQ_STAT    8'h4C
`define OSS_ADR_IRQ_CLR     8'h50
`define OSS_ADR_IRQ_EN      8'h54

// threshold register indices, counted in words from the threshold base
`define OSS_THR_COUNT       9
`define OSS_THR_ZERO        4'h0
`define OSS_THR_DEV         4'h1
`define OSS_THR_SP2         4'h2
`define OSS_THR_OL2         4'h3
`define OSS_THR_VLOSS       4'h4
`define OSS_THR_CLOSS       4'h5
`define OSS_THR_FBLO        4'h6
`define OSS_THR_FBHI        4'h7
`define OSS_THR_WDP         4'h8

// interrupt status bit positions
`define OSS_IRQ_BITS        7
`define OSS_IRQ_WD          0
`define OSS_IRQ_VLOSS       1
`define OSS_IRQ_CLOSS       2
`define OSS_IRQ_FB          3
`define OSS_IRQ_CAP         4
`define OSS_IRQ_FAN         5
`define OSS_IRQ_RS          6

`endif

// >>> oss_pkg.sv
// types shared by the status selector modules
package oss_pkg;

  typedef logic [7:0] oss_func_t;

  // internal conditions that a terminal may carry
  typedef struct packed {
    logic fanLifeFlag;
    logic capacitorLifeFlag;
    logic boolResultC;
    logic boolResultB;
    logic boolResultA;
    logic commTimeoutFlag;
    logic feedbackWindowFlag;
    logic currInputLossFlag;
    logic voltInputLossFlag;
    logic overloadWarn2Flag;
    logic freqAtSetpoint2Flag;
    logic freqOverSetpoint2Flag;
    logic positionDoneFlag;
    logic speedDeviationFlag;
    logic zeroFreqFlag;
  } oss_cond_s;

  // terminal output states
  typedef enum logic [3:0] {
    OSS_OFF   = 4'b0001,
    OSS_ON    = 4'b0010,
    OSS_DELAY = 4'b0100,
    OSS_HOLD  = 4'b1000
  } oss_term_e;

endpackage : oss_pkg

// >>> oss_off_delay.sv
// one terminal driver: off delay and reset-input hold
`include "oss_regs.svh"

module oss_off_delay #(
  parameter int unsigned CW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          level,
  input  wire logic          rsLevel,
  input  wire logic          tenthTick,
  input  wire logic [CW-1:0] offDelay,
  output logic               termOut
);

  oss_pkg::oss_term_e state;
  oss_pkg::oss_term_e next_state;
  logic [CW-1:0]      cnt;
  logic [CW-1:0]      next_cnt;

  wire logic          delayOn  = offDelay != '0;
  wire logic          cntDone  = cnt == '0;
  wire logic [CW-1:0] holdLoad = CW'(`OSS_RS_HOLD_TENTHS);
  wire logic [CW-1:0] cntDec   = tenthTick ? cnt - CW'(1) : cnt;

  // next state; reset input overrides the level
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      oss_pkg::OSS_OFF: begin
        if (level && !rsLevel) begin
          next_state = oss_pkg::OSS_ON;
        end
      end
      oss_pkg::OSS_ON: begin
        if (rsLevel && delayOn) begin
          next_state = oss_pkg::OSS_HOLD;
          next_cnt   = holdLoad;
        end else if (rsLevel) begin
          next_state = oss_pkg::OSS_OFF;
        end else if (!level && delayOn) begin
          next_state = oss_pkg::OSS_DELAY;
          next_cnt   = offDelay;
        end else if (!level) begin
          next_state = oss_pkg::OSS_OFF;
        end
      end
      oss_pkg::OSS_DELAY: begin
        if (rsLevel) begin
          next_state = oss_pkg::OSS_HOLD;
          next_cnt   = holdLoad;
        end else if (level) begin
          next_state = oss_pkg::OSS_ON;
        end else if (cntDone) begin
          next_state = oss_pkg::OSS_OFF;
        end else begin
          next_cnt = cntDec;
        end
      end
      oss_pkg::OSS_HOLD: begin
        // hold ignores the level for about one second
        if (cntDone) begin
          next_state = oss_pkg::OSS_OFF;
        end else begin
          next_cnt = cntDec;
        end
      end
      default: begin
        next_state = oss_pkg::OSS_OFF;
      end
    endcase
  end

  // state, counter and terminal flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= oss_pkg::OSS_OFF;
      cnt     <= '0;
      termOut <= 1'b0;
    end else if (ce) begin
      state   <= next_state;
      cnt     <= next_cnt;
      termOut <= next_state != oss_pkg::OSS_OFF;
    end
  end

endmodule : oss_off_delay

// >>> oss_status_select.sv
// output terminal status generator and selector with a wishbone register slave
`include "oss_regs.svh"

module oss_status_select #(
  parameter int unsigned NUM_OUT   = 3,
  parameter int unsigned DW        = 16,
  parameter int unsigned MS_CYCLES = `OSS_MS_NS / `OSS_CLK_PERIOD_NS
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [DW-1:0]      outFreq,
  input  wire logic [DW-1:0]      speedCmd,
  input  wire logic [DW-1:0]      speedMeas,
  input  wire logic [DW-1:0]      outCurrent,
  input  wire logic [DW-1:0]      analogVolt,
  input  wire logic [DW-1:0]      analogCurr,
  input  wire logic [DW-1:0]      feedbackPv,
  input  wire logic               running,
  input  wire logic               positionDone,
  input  wire logic [2:0]         boolResult,
  input  wire logic               capLifeExpired,
  input  wire logic               fanLifeExpired,
  input  wire logic               commActivity,
  input  wire logic               driveResetInput,
  output logic      [NUM_OUT-1:0] outTerm,
  output logic                    irq
);

  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);

  // parameters the address map and counters cannot serve
  if (NUM_OUT < 1 || NUM_OUT > 4) begin : gBadNumOut
    $error("oss_status_select: NUM_OUT must be 1 to 4");
  end
  if (DW < 8 || DW > 32) begin : gBadDw
    $error("oss_status_select: DW must be 8 to 32");
  end
  if (MS_CYCLES < 1) begin : gBadMs
    $error("oss_status_select: MS_CYCLES must be at least 1");
  end

  // byte-enable merge of a bus write into a register image
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // condition picked by a terminal function code
  function automatic logic pickCond(input oss_pkg::oss_func_t code, input oss_pkg::oss_cond_s c);
    logic r;
    r = 1'b0;
    case (code)
      `OSS_FC_ZERO_FREQ:  r = c.zeroFreqFlag;
      `OSS_FC_SPEED_DEV:  r = c.speedDeviationFlag;
      `OSS_FC_POS_DONE:   r = c.positionDoneFlag;
      `OSS_FC_FREQ_OVER2: r = c.freqOverSetpoint2Flag;
      `OSS_FC_FREQ_AT2:   r = c.freqAtSetpoint2Flag;
      `OSS_FC_OVERLOAD2:  r = c.overloadWarn2Flag;
      `OSS_FC_VOLT_LOSS:  r = c.voltInputLossFlag;
      `OSS_FC_CURR_LOSS:  r = c.currInputLossFlag;
      `OSS_FC_FB_WINDOW:  r = c.feedbackWindowFlag;
      `OSS_FC_COMM_TMO:   r = c.commTimeoutFlag;
      `OSS_FC_BOOL_A:     r = c.boolResultA;
      `OSS_FC_BOOL_B:     r = c.boolResultB;
      `OSS_FC_BOOL_C:     r = c.boolResultC;
      `OSS_FC_CAP_LIFE:   r = c.capacitorLifeFlag;
      `OSS_FC_FAN_LIFE:   r = c.fanLifeFlag;
      default:            r = 1'b0;
    endcase
    return r;
  endfunction : pickCond

  // register file
  oss_pkg::oss_func_t       funcCode [NUM_OUT];
  logic [15:0]              offDelay [NUM_OUT];
  logic [DW-1:0]            thr      [`OSS_THR_COUNT];
  logic [`OSS_IRQ_BITS-1:0] irqEn;
  logic [`OSS_IRQ_BITS-1:0] irqStat;
  logic [`OSS_IRQ_BITS-1:0] next_irqStat;

  // internal state
  oss_pkg::oss_cond_s cond;
  logic               rsMeta;
  logic               rsSync;
  logic               rsPrev;
  logic [MSW-1:0]     msCount;
  logic [6:0]         tenthCount;
  logic [DW-1:0]      wdCount;
  logic               commTimeout;
  logic               fbWindow;
  logic               runPrev;
  logic [`OSS_IRQ_BITS-1:0] evPrev;

  // bus decode: a write lands on the edge where ack is seen high
  wire logic        busReq   = wb_cyc_i & wb_stb_i;
  wire logic        busStart = busReq & ~wb_ack_o;
  wire logic        busWrite = ce & busReq & wb_we_i & wb_ack_o;
  wire logic [5:0]  thrWord  = wb_adr_i[7:2] - 6'(`OSS_ADR_THR_BASE >> 2);
  wire logic        thrHit   = thrWord < 6'(`OSS_THR_COUNT);
  wire logic        clrHit   = busWrite && wb_adr_i == `OSS_ADR_IRQ_CLR;
  wire logic        enHit    = busWrite && wb_adr_i == `OSS_ADR_IRQ_EN;
  wire logic [31:0] clrWord  = mergeBytes(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire logic [31:0] enWord   = mergeBytes(32'(irqEn), wb_dat_i, wb_sel_i);

  // read selection; unmapped and write-only offsets read as zero
  function automatic logic [31:0] readValue(input logic [7:0] adr);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (adr == 8'(`OSS_ADR_FUNC_BASE + 4 * i)) begin
        v = 32'(funcCode[i]);
      end
      if (adr == 8'(`OSS_ADR_OFFDLY_BASE + 4 * i)) begin
        v = 32'(offDelay[i]);
      end
    end
    for (int k = 0; k < `OSS_THR_COUNT; k++) begin
      if (adr == 8'(`OSS_ADR_THR_BASE + 4 * k)) begin
        v = 32'(thr[k]);
      end
    end
    if (adr == `OSS_ADR_COND) begin
      v = 32'(cond);
    end
    if (adr == `OSS_ADR_TERM) begin
      v = 32'(outTerm);
    end
    if (adr == `OSS_ADR_IRQ_STAT) begin
      v = 32'(irqStat);
    end
    if (adr == `OSS_ADR_IRQ_EN) begin
      v = 32'(irqEn);
    end
    return v;
  endfunction : readValue

  wire logic [31:0] readData = readValue(wb_adr_i);

  // ack one cycle after the request; data held while ack stands
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= busStart;
      if (busStart) begin
        wb_dat_o <= readData;
      end
    end
  end

  // threshold registers; unused high byte lanes are dropped by the cast
  for (genvar k = 0; k < `OSS_THR_COUNT; k++) begin : gThr
    wire logic hit = busWrite && thrHit && wb_adr_i[1:0] == 2'b00 && thrWord == 6'(k);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        thr[k] <= '0;
      end else if (hit) begin
        thr[k] <= DW'(mergeBytes(32'(thr[k]), wb_dat_i, wb_sel_i));
      end
    end
  end

  // reset input is a pin: two flops before anything reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsMeta <= 1'b0;
      rsSync <= 1'b0;
      rsPrev <= 1'b0;
    end else if (ce) begin
      rsMeta <= driveResetInput;
      rsSync <= rsMeta;
      rsPrev <= rsSync;
    end
  end

  // millisecond and tenth-second ticks
  wire logic msTick    = ce && msCount == MSW'(MS_CYCLES - 1);
  wire logic tenthTick = msTick && tenthCount == 7'(`OSS_TENTH_MS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCount    <= '0;
      tenthCount <= 7'h00;
    end else if (ce) begin
      msCount    <= msTick ? '0 : msCount + MSW'(1);
      if (msTick) begin
        tenthCount <= tenthTick ? 7'h00 : tenthCount + 7'h01;
      end
    end
  end

  // comparator conditions; frequency arrival flags drop when output stops
  wire logic [DW-1:0] speedDiff = (speedCmd > speedMeas) ? speedCmd - speedMeas
                                                          : speedMeas - speedCmd;
  wire logic          outActive = running && outFreq != '0;

  assign cond.zeroFreqFlag          = outFreq < thr[`OSS_THR_ZERO];
  assign cond.speedDeviationFlag    = speedDiff > thr[`OSS_THR_DEV];
  assign cond.positionDoneFlag      = positionDone;
  assign cond.freqOverSetpoint2Flag = outActive && outFreq >= thr[`OSS_THR_SP2];
  assign cond.freqAtSetpoint2Flag   = outActive && outFreq == thr[`OSS_THR_SP2];
  assign cond.overloadWarn2Flag     = outCurrent > thr[`OSS_THR_OL2];
  assign cond.voltInputLossFlag     = analogVolt < thr[`OSS_THR_VLOSS];
  assign cond.currInputLossFlag     = analogCurr < thr[`OSS_THR_CLOSS];
  assign cond.feedbackWindowFlag    = fbWindow;
  assign cond.commTimeoutFlag       = commTimeout;
  assign cond.boolResultA           = boolResult[0];
  assign cond.boolResultB           = boolResult[1];
  assign cond.boolResultC           = boolResult[2];
  assign cond.capacitorLifeFlag     = capLifeExpired;
  assign cond.fanLifeFlag           = fanLifeExpired;

  // feedback window latch; a set in the same cycle as a clear wins
  wire logic fbSet = running && feedbackPv < thr[`OSS_THR_FBLO];
  wire logic fbClr = feedbackPv > thr[`OSS_THR_FBHI] || (runPrev && !running);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fbWindow <= 1'b0;
      runPrev  <= 1'b0;
    end else if (ce) begin
      runPrev  <= running;
      fbWindow <= fbSet || (fbWindow && !fbClr);
    end
  end

  // watchdog counts ms since activity; period zero disables it
  wire logic [DW-1:0] wdPeriod = thr[`OSS_THR_WDP];
  wire logic          wdExpire = msTick && wdPeriod != '0 && wdCount + DW'(1) >= wdPeriod;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdCount     <= '0;
      commTimeout <= 1'b0;
    end else if (ce) begin
      if (commActivity || wdPeriod == '0) begin
        wdCount     <= '0;
        commTimeout <= 1'b0;
      end else if (msTick && !commTimeout) begin
        wdCount     <= wdCount + DW'(1);
        commTimeout <= wdExpire;
      end
    end
  end

  // per-terminal code, off delay and driver
  for (genvar i = 0; i < NUM_OUT; i++) begin : gTerm
    wire logic hitFunc = busWrite && wb_adr_i == 8'(`OSS_ADR_FUNC_BASE + 4 * i);
    wire logic hitDly  = busWrite && wb_adr_i == 8'(`OSS_ADR_OFFDLY_BASE + 4 * i);
    wire logic level   = pickCond(funcCode[i], cond);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        funcCode[i] <= `OSS_FUNC_RST;
        offDelay[i] <= 16'h0000;
      end else begin
        if (hitFunc) begin
          funcCode[i] <= 8'(mergeBytes(32'(funcCode[i]), wb_dat_i, wb_sel_i));
        end
        if (hitDly) begin
          offDelay[i] <= 16'(mergeBytes(32'(offDelay[i]), wb_dat_i, wb_sel_i));
        end
      end
    end

    oss_off_delay #(
      .CW(16)
    ) uDelay (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .level    (level),
      .rsLevel  (rsSync),
      .tenthTick(tenthTick),
      .offDelay (offDelay[i]),
      .termOut  (outTerm[i])
    );
  end

  // interrupt events are rising edges
  wire logic [`OSS_IRQ_BITS-1:0] evNow = {rsSync, fanLifeExpired, capLifeExpired, fbWindow,
                                          cond.currInputLossFlag, cond.voltInputLossFlag,
                                          commTimeout};
  wire logic [`OSS_IRQ_BITS-1:0] evRise = ce ? evNow & ~evPrev : '0;

  // sticky status: a new event wins over a clear in the same cycle
  assign next_irqStat = (irqStat & ~(clrHit ? clrWord[`OSS_IRQ_BITS-1:0] : '0)) | evRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evPrev  <= '0;
      irqStat <= '0;
      irqEn   <= '0;
      irq     <= 1'b0;
    end else if (ce) begin
      evPrev  <= evNow;
      irqStat <= next_irqStat;
      if (enHit) begin
        irqEn <= enWord[`OSS_IRQ_BITS-1:0];
      end
      irq <= |(next_irqStat & (enHit ? enWord[`OSS_IRQ_BITS-1:0] : irqEn));
    end
  end

endmodule : oss_status_select

// >>> oss_term_monitor.sv
// model of the external equipment that reads the output terminals
module oss_term_monitor #(
  parameter int unsigned N = 3
) (
  input  wire logic         clk,
  input  wire logic         clr,
  input  wire logic [N-1:0] term,
  output logic      [N-1:0] seen,
  output int unsigned       onCnt
);
  // latches the pins and times terminal 0
  always_ff @(posedge clk) begin
    seen <= term;
    onCnt <= clr ? 0 : onCnt + 32'(term[0]);
  end
endmodule : oss_term_monitor

// >>> oss_status_select_checker.sv
// assertions on the selector ports
`include "oss_regs.svh"
module oss_status_select_checker #(
  parameter int unsigned NUM_OUT   = 3,
  parameter int unsigned DW        = 16,
  parameter int unsigned MS_CYCLES = 20
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_i,
  input wire logic               wb_ack_o,
  input wire logic [DW-1:0]      outFreq,
  input wire logic [DW-1:0]      outCurrent,
  input wire logic [DW-1:0]      analogVolt,
  input wire logic [DW-1:0]      analogCurr,
  input wire logic [DW-1:0]      feedbackPv,
  input wire logic               running,
  input wire logic               positionDone,
  input wire logic [2:0]         boolResult,
  input wire logic               capLifeExpired,
  input wire logic               fanLifeExpired,
  input wire logic               driveResetInput,
  input wire logic [NUM_OUT-1:0] outTerm
);
  localparam int unsigned RS_LIM = 11 * 100 * MS_CYCLES + 8;
  logic [7:0]    func0;
  logic [15:0]   off0;
  logic [DW-1:0] thr [9];
  logic [2:0]    settle;
  int unsigned   rsCnt;
  wire           wrAck = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire [7:0]     thrIdx = (wb_adr_i - `OSS_ADR_THR_BASE) >> 2;
  // check terminals only after writes settle
  wire           quiet = settle == 3'h7 && off0 == 16'h0000 && ce;
  // shadows of bus writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func0 <= `OSS_FUNC_RST;
      off0 <= 16'h0000;
      thr <= '{default: '0};
    end else if (wrAck) begin
      if (wb_adr_i == `OSS_ADR_FUNC_BASE) func0 <= wb_dat_i[7:0];
      if (wb_adr_i == `OSS_ADR_OFFDLY_BASE) off0 <= wb_dat_i[15:0];
      if (wb_adr_i >= `OSS_ADR_THR_BASE && wb_adr_i <= 8'h40) thr[thrIdx[3:0]] <= wb_dat_i[DW-1:0];
    end
  end
  // settle and reset-input counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 3'h0;
      rsCnt <= 0;
    end else begin
      settle <= (wrAck || driveResetInput || !ce) ? 3'h0 : settle + 3'(settle != 3'h7);
      rsCnt <= driveResetInput ? rsCnt + 32'(rsCnt != RS_LIM) : 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_sel(logic [7:0] c, logic e);
    quiet && func0 == c |=> outTerm[0] == $past(e);
  endproperty
  AST_ACK_PULSE: assert property (s_req |=> s_pulse) else $error("ack not one pulse");
  AST_ZERO_FREQ: assert property (p_sel(`OSS_FC_ZERO_FREQ, outFreq < thr[0]))
    else $error("zero freq");
  AST_POS_DONE: assert property (p_sel(`OSS_FC_POS_DONE, positionDone))
    else $error("position");
  AST_FREQ_OVER2: assert property (p_sel(`OSS_FC_FREQ_OVER2, running && outFreq != '0 && outFreq >= thr[2]))
    else $error("over setpoint");
  AST_FREQ_AT2: assert property (p_sel(`OSS_FC_FREQ_AT2, running && outFreq != '0 && outFreq == thr[2]))
    else $error("at setpoint");
  AST_OVERLOAD2: assert property (p_sel(`OSS_FC_OVERLOAD2, outCurrent > thr[3]))
    else $error("overload");
  AST_VOLT_LOSS: assert property (p_sel(`OSS_FC_VOLT_LOSS, analogVolt < thr[4]))
    else $error("voltage loss");
  AST_CURR_LOSS: assert property (p_sel(`OSS_FC_CURR_LOSS, analogCurr < thr[5]))
    else $error("current loss");
  AST_BOOL: assert property (quiet && func0 inside {[8'h21:8'h23]} |=>
    outTerm[0] == $past(boolResult[func0[1:0] - 2'h1])) else $error("boolean");
  AST_CAP_LIFE: assert property (p_sel(`OSS_FC_CAP_LIFE, capLifeExpired))
    else $error("capacitor");
  AST_FAN_LIFE: assert property (p_sel(`OSS_FC_FAN_LIFE, fanLifeExpired))
    else $error("fan");
  AST_FB_SET: assert property (quiet && func0 == `OSS_FC_FB_WINDOW && running && feedbackPv < thr[6]
    |=> ##1 outTerm[0]) else $error("feedback set");
  AST_FB_CLR: assert property (quiet && func0 == `OSS_FC_FB_WINDOW && !(running && feedbackPv < thr[6])
    && (!running || feedbackPv > thr[7]) |=> ##1 !outTerm[0]) else $error("feedback clear");
  AST_UNUSED: assert property (quiet && !(func0 inside {[8'h15:8'h1C], [8'h1F:8'h23], 8'h27, 8'h28})
    |=> !outTerm[0]) else $error("unused code");
  AST_RS_OFF: assert property (rsCnt == RS_LIM |-> outTerm == '0) else $error("reset hold too long");
endmodule : oss_status_select_checker

// >>> oss_status_select_test.sv
// self-checking bench for the terminal status selector
`include "oss_regs.svh"
module oss_status_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned NUM_OUT = 3;
  localparam int unsigned DW = 16;
  localparam int unsigned MS_CYCLES = 20;
  logic clk = 1'h0, rst_n = 1'h0, ce = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic        wb_ack_o, irq, monClr = 1'h0;
  logic [DW-1:0] outFreq = '0, speedCmd = '0, speedMeas = '0, outCurrent = '0, analogVolt = '0;
  logic [DW-1:0] analogCurr = '0, feedbackPv = '0, thr [9];
  logic running = 1'h0, positionDone = 1'h0, capLifeExpired = 1'h0, fanLifeExpired = 1'h0;
  logic commActivity = 1'h0, driveResetInput = 1'h0;
  logic [2:0]  boolResult = 3'h0;
  logic [NUM_OUT-1:0] outTerm, seen;
  int unsigned onCnt;
  int          n_mismatch = 0, checks_done = 0, n, seed = 32'h8ba1_76e4;
  logic [7:0]  codes [15] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C,
                              8'h21, 8'h22, 8'h23, 8'h27, 8'h28, 8'h30, 8'hFF};
  logic [17:0] fbTab [6] = '{18'h2_000F, 18'h2_001F, 18'h2_0030, 18'h2_001C, 18'h2_000F, 18'h0_000C};
  always #25 clk = ~clk;
  oss_status_select #(.NUM_OUT(NUM_OUT), .DW(DW), .MS_CYCLES(MS_CYCLES)) i_oss_status_select (.*);
  oss_term_monitor #(.N(NUM_OUT)) i_oss_term_monitor (.clk(clk), .clr(monClr), .term(outTerm),
    .seen(seen), .onCnt(onCnt));
  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  // one classic wishbone cycle, released after ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'h1 && n++ < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    chk(n < 20, 1'h1, "no ack");
  endtask : wb
  task automatic setThr(input int k, input logic [DW-1:0] v);
    thr[k] = v;
    wb(1'h1, `OSS_ADR_THR_BASE + 8'(4 * k), 32'(v));
  endtask : setThr
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step
  // small values hit thresholds often
  task automatic randIn(input logic hit);
    @(posedge clk);
    outFreq <= hit ? thr[2] : DW'($random(seed) & 4'hF);
    {speedCmd, speedMeas} <= {DW'($random(seed) & 4'hF), DW'($random(seed) & 4'hF)};
    {outCurrent, analogVolt} <= {DW'($random(seed) & 4'hF), DW'($random(seed) & 4'hF)};
    analogCurr <= DW'($random(seed) & 4'hF);
    {running, positionDone, boolResult, capLifeExpired, fanLifeExpired} <= 7'($random(seed)) | {hit, 6'h00};
  endtask : randIn
  function automatic logic expFlag(input logic [7:0] c);
    case (c)
      `OSS_FC_ZERO_FREQ: return outFreq < thr[0];
      `OSS_FC_SPEED_DEV: return (speedCmd > speedMeas ? speedCmd - speedMeas : speedMeas - speedCmd) > thr[1];
      `OSS_FC_POS_DONE: return positionDone;
      `OSS_FC_FREQ_OVER2: return running && outFreq != '0 && outFreq >= thr[2];
      `OSS_FC_FREQ_AT2: return running && outFreq != '0 && outFreq == thr[2];
      `OSS_FC_OVERLOAD2: return outCurrent > thr[3];
      `OSS_FC_VOLT_LOSS: return analogVolt < thr[4];
      `OSS_FC_CURR_LOSS: return analogCurr < thr[5];
      `OSS_FC_BOOL_A, `OSS_FC_BOOL_B, `OSS_FC_BOOL_C: return boolResult[c[1:0] - 2'h1];
      `OSS_FC_CAP_LIFE: return capLifeExpired;
      `OSS_FC_FAN_LIFE: return fanLifeExpired;
      default: return 1'h0;
    endcase
  endfunction : expFlag
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    for (int k = 0; k < 9; k++) setThr(k, k < 8 ? DW'($random(seed) & 4'hF) : DW'(0));
    wb(1'h1, 8'h04, 32'h0000_0017);
    wb(1'h1, 8'h08, 32'h0000_0030);
    foreach (codes[i]) begin
      wb(1'h1, `OSS_ADR_FUNC_BASE, 32'(codes[i]));
      for (int j = 0; j < 8; j++) begin
        randIn(j == 0);
        step();
        chk(outTerm[0], expFlag(codes[i]), "selected terminal");
        chk(outTerm[1], positionDone, "second terminal");
        chk(outTerm[2], 1'h0, "unused terminal");
      end
    end
    wb(1'h1, `OSS_ADR_FUNC_BASE, 32'h0000_001F);
    setThr(6, 16'h000A);
    setThr(7, 16'h0014);
    foreach (fbTab[i]) begin
      @(posedge clk);
      {running, feedbackPv} <= fbTab[i][17:1];
      step();
      step();
      chk(outTerm[0], fbTab[i][0], "feedback window");
    end
    wb(1'h1, `OSS_ADR_FUNC_BASE, 32'h0000_0020);
    wb(1'h1, `OSS_ADR_IRQ_EN, 32'h0000_0001);
    setThr(8, 16'h0002);
    repeat (10) begin
      @(posedge clk) commActivity <= 1'h1;
      @(posedge clk) commActivity <= 1'h0;
      repeat (8) @(posedge clk);
    end
    @(negedge clk);
    chk(outTerm[0] | irq, 1'h0, "watchdog early");
    for (n = 0; outTerm[0] !== 1'h1 && n < 100; n++) step();
    chk(n >= 14 && n <= 33, 1'h1, "watchdog span");
    step();
    chk(irq, 1'h1, "irq not raised");
    wb(1'h0, `OSS_ADR_IRQ_STAT, 32'h0000_0000);
    chk(rd[`OSS_IRQ_WD], 1'h1, "status bit");
    wb(1'h1, `OSS_ADR_IRQ_EN, 32'h0000_0000);
    step();
    chk(irq, 1'h0, "irq not masked");
    wb(1'h1, `OSS_ADR_IRQ_EN, 32'h0000_0001);
    wb(1'h1, `OSS_ADR_IRQ_CLR, 32'h0000_0001);
    step();
    chk(irq, 1'h0, "irq not cleared");
    wb(1'h0, 8'h60, 32'h0000_0000);
    chk(rd === 32'h0000_0000, 1'h1, "unmapped read");
    @(posedge clk) commActivity <= 1'h1;
    @(posedge clk) commActivity <= 1'h0;
    step();
    chk(outTerm[0], 1'h0, "watchdog not satisfied");
    wb(1'h1, `OSS_ADR_FUNC_BASE, 32'h0000_0017);
    wb(1'h1, `OSS_ADR_OFFDLY_BASE, 32'h0000_0005);
    @(posedge clk) positionDone <= 1'h1;
    step();
    @(posedge clk) {driveResetInput, monClr} <= 2'h3;
    @(posedge clk) monClr <= 1'h0;
    repeat (5) step();
    chk(outTerm[1], 1'h0, "no-delay terminal held");
    chk(outTerm[0], 1'h1, "delayed terminal dropped");
    repeat (23000) @(posedge clk);
    @(negedge clk);
    chk(seen[0], 1'h0, "terminal still on");
    chk(onCnt >= 17990 && onCnt <= 20020, 1'h1, "hold span");
    complete_run();
  end
  // hang guard
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule : oss_status_select_test
bind oss_status_select oss_status_select_checker #(.NUM_OUT(NUM_OUT), .DW(DW),
  .MS_CYCLES(MS_CYCLES)) i_oss_status_select_checker (.*);
